// ---- src/bdu_match_regs.v ----
// bdu_match_regs.v: comparator match registers of the bus debug unit,
// APB slave window, arm and visibility control, match outputs
// assumes: one clock, bus inputs synchronous, one bus cycle per clock
//
// Overview of operation
// - The address-mid byte of the visible comparator holds address bits 15:8 at index 0x2A.
// - The address-low byte of the visible comparator holds address bits 7:0 at index 0x2B.
// - Each stored address bit must equal the bus address bit for an address match.
// - Address registers read armed or not, except at visibility 11, and are written only while not armed.
// - The visibility field picks the first, second, third or no comparator for the window.
// - Data and mask registers read back only when visibility is 00, else zero.
// - Data and mask registers are written only when visibility is 00 and not armed.
// - The data-high byte holds expected data bits 15:8.
// - The data-low byte holds expected data bits 7:0.
// - A data bit is compared only where its mask bit is 1.
// - Mask bytes cover data bits 15:8 and 7:0; 0 lets any value match.
// - Data compare applies only while the first comparator's tag bit is clear.
// - Only the first comparator has data and mask registers.
// - The address-high byte holds address bits 17:16, giving an 18-bit compare.
// - Setting the arm bit arms the unit, which locks comparator registers.
`timescale 1ns/1ps
`default_nettype none
`include "bdu_consts.vh"

module bdu_match_regs (
   input  wire        clock_in,
   input  wire        rst_in,
   input  wire        ce_in,
   input  wire        psel_in,
   input  wire        penable_in,
   input  wire        pwrite_in,
   input  wire [7:0]  paddr_in,
   input  wire [31:0] pwdata_in,
   output reg  [31:0] prdata_out,
   output reg         pready_out,
   output reg         pslverr_out,
   input  wire        bus_valid_in,
   input  wire [17:0] bus_addr_in,
   input  wire [15:0] bus_data_in,
   output reg  [2:0]  match_out,
   output reg         armed_out
);
   reg        arm_q;
   reg [1:0]  vis_q;
   reg        tag_q;
   reg [2:0]  match_q;
   reg [31:0] rdata_d;
   reg        mapped_d;

   wire        setup   = psel_in & ~penable_in;
   wire        wr_acc  = psel_in & penable_in & pready_out & pwrite_in;
   wire        idx_ok  = (paddr_in[1:0] == 2'h0);
   wire [5:0]  idx     = paddr_in[7:2];
   wire        vis_a   = (vis_q == `BDU_VIS_FIRST);
   wire [7:0]  wb      = pwdata_in[7:0];

   wire        wr_ok   = wr_acc & idx_ok & ~arm_q;
   // data writes need visibility 00 and disarmed
   wire        wr_dok  = wr_ok & vis_a;

   wire [17:0] addr_val [0:`BDU_NUM_CMP-1];
   wire [2:0]  addr_hit;
   wire [15:0] dat_val;
   wire [15:0] msk_val;
   wire        dat_hit;

   genvar g;
   generate
      for (g = 0; g < `BDU_NUM_CMP; g = g + 1) begin : g_cmp
         // only the visible comparator takes writes
         wire sel = wr_ok & ({30'h0, vis_q} == g);
         bdu_addr_cmp u_addr (
            .clock_in    (clock_in),
            .rst_in      (rst_in),
            .ce_in       (ce_in),
            .wr_high_in  (sel & (idx == `BDU_IDX_ADDR_HIGH)),
            .wr_mid_in   (sel & (idx == `BDU_IDX_ADDR_MID)),
            .wr_low_in   (sel & (idx == `BDU_IDX_ADDR_LOW)),
            .wdata_in    (wb),
            .bus_addr_in (bus_addr_in),
            .value_out   (addr_val[g]),
            .hit_out     (addr_hit[g])
         );
      end
   endgenerate

   // single data store, first comparator only
   bdu_data_cmp u_data (
      .clock_in    (clock_in),
      .rst_in      (rst_in),
      .ce_in       (ce_in),
      .wr_dh_in    (wr_dok & (idx == `BDU_IDX_DATA_HIGH)),
      .wr_dl_in    (wr_dok & (idx == `BDU_IDX_DATA_LOW)),
      .wr_mh_in    (wr_dok & (idx == `BDU_IDX_MASK_HIGH)),
      .wr_ml_in    (wr_dok & (idx == `BDU_IDX_MASK_LOW)),
      .wdata_in    (wb),
      .bus_data_in (bus_data_in),
      .data_out    (dat_val),
      .mask_out    (msk_val),
      .hit_out     (dat_hit)
   );

   // control registers
   always @(posedge clock_in) begin
      if (rst_in) begin
         arm_q <= 1'b0;
         vis_q <= `BDU_RST_VIS;
         tag_q <= 1'b0;
      end else if (ce_in) begin
         if (wr_acc & idx_ok & (idx == `BDU_IDX_CTRL_ONE)) begin
            // arm bit sets and clears armed state
            arm_q <= wb[`BDU_CTL_ARM_BIT];
            vis_q <= wb[`BDU_CTL_VIS_LSB+1:`BDU_CTL_VIS_LSB];
         end
         if (wr_ok & (idx == `BDU_IDX_CTRL_FIRST)) begin
            tag_q <= wb[`BDU_FCC_TAG_BIT];
         end
      end
   end

   // read mux
   always @* begin
      rdata_d  = 32'h0000_0000;
      mapped_d = idx_ok;
      case (idx)
         `BDU_IDX_CTRL_ONE: begin
            rdata_d[`BDU_CTL_ARM_BIT] = arm_q;
            rdata_d[`BDU_CTL_VIS_LSB+1:`BDU_CTL_VIS_LSB] = vis_q;
         end
         `BDU_IDX_CTRL_FIRST: begin
            rdata_d[`BDU_FCC_TAG_BIT] = tag_q;
         end
         `BDU_IDX_MATCH: begin
            rdata_d[`BDU_MATCH_LSB+2:`BDU_MATCH_LSB] = match_q;
         end
         `BDU_IDX_ADDR_HIGH: begin
            if (vis_q != `BDU_VIS_NONE) begin
               rdata_d[1:0] = addr_val[vis_q][17:16];
            end
         end
         `BDU_IDX_ADDR_MID: begin
            if (vis_q != `BDU_VIS_NONE) begin
               rdata_d[7:0] = addr_val[vis_q][15:8];
            end
         end
         `BDU_IDX_ADDR_LOW: begin
            if (vis_q != `BDU_VIS_NONE) begin
               rdata_d[7:0] = addr_val[vis_q][7:0];
            end
         end
         // data window reads only at visibility 00
         `BDU_IDX_DATA_HIGH: begin
            if (vis_a) begin
               rdata_d[7:0] = dat_val[15:8];
            end
         end
         `BDU_IDX_DATA_LOW: begin
            if (vis_a) begin
               rdata_d[7:0] = dat_val[7:0];
            end
         end
         `BDU_IDX_MASK_HIGH: begin
            if (vis_a) begin
               rdata_d[7:0] = msk_val[15:8];
            end
         end
         `BDU_IDX_MASK_LOW: begin
            if (vis_a) begin
               rdata_d[7:0] = msk_val[7:0];
            end
         end
         default: begin
            mapped_d = 1'b0;
         end
      endcase
   end

   // apb answer: one wait state, ready in second access cycle
   always @(posedge clock_in) begin
      if (rst_in) begin
         prdata_out  <= 32'h0000_0000;
         pready_out  <= 1'b0;
         pslverr_out <= 1'b0;
      end else if (ce_in) begin
         if (psel_in & penable_in & ~pready_out) begin
            pready_out  <= 1'b1;
            pslverr_out <= ~mapped_d;
            prdata_out  <= pwrite_in ? 32'h0000_0000 : (mapped_d ? rdata_d : 32'h0000_0000);
         end else begin
            pready_out  <= 1'b0;
            pslverr_out <= 1'b0;
            prdata_out  <= 32'h0000_0000;
         end
      end
   end

   // match outputs, registered
   always @(posedge clock_in) begin
      if (rst_in) begin
         match_q   <= 3'h0;
         match_out <= 3'h0;
         armed_out <= 1'b0;
      end else if (ce_in) begin
         // address and unmasked data agree in same cycle
         match_q[0] <= bus_valid_in & addr_hit[0] & (tag_q | dat_hit);
         match_q[2:1] <= {2{bus_valid_in}} & addr_hit[2:1];
         match_out  <= {bus_valid_in & addr_hit[2], bus_valid_in & addr_hit[1],
                        bus_valid_in & addr_hit[0] & (tag_q | dat_hit)};
         armed_out  <= arm_q;
      end
   end

   wire unused_ok = setup;
endmodule // bdu_match_regs

`default_nettype wire

// ---- src/bdu_consts.vh ----
// bdu_consts.vh: offsets, field positions and reset values of the
// bus debug unit comparator register window
// assumes: included by the design files of the block only
`ifndef BDU_CONSTS_VH
`define BDU_CONSTS_VH

// printed byte offsets; not all are multiples of four, so they are indices
`define BDU_IDX_ADDR_HIGH   6'h29
`define BDU_IDX_ADDR_MID    6'h2A
`define BDU_IDX_ADDR_LOW    6'h2B
`define BDU_IDX_DATA_HIGH   6'h2C
`define BDU_IDX_DATA_LOW    6'h2D
`define BDU_IDX_MASK_HIGH   6'h2E
`define BDU_IDX_MASK_LOW    6'h2F
// added control registers
`define BDU_IDX_CTRL_ONE    6'h20
`define BDU_IDX_CTRL_FIRST  6'h21
`define BDU_IDX_MATCH       6'h22

// debug_control_one fields
`define BDU_CTL_ARM_BIT     7
`define BDU_CTL_VIS_LSB     0
// first_comparator_control fields
`define BDU_FCC_TAG_BIT     5
// match status fields
`define BDU_MATCH_LSB       0

`define BDU_VIS_FIRST       2'h0
`define BDU_VIS_SECOND      2'h1
`define BDU_VIS_THIRD       2'h2
`define BDU_VIS_NONE        2'h3

`define BDU_RST_BYTE        8'h00
`define BDU_RST_HIGH        2'h0
`define BDU_RST_VIS         2'h0

`define BDU_NUM_CMP         3

`endif

// ---- src/bdu_addr_cmp.v ----
// bdu_addr_cmp.v: one comparator's 18-bit address compare store
// assumes: write strobes already qualified by window visibility and arm
`timescale 1ns/1ps
`default_nettype none
`include "bdu_consts.vh"

module bdu_addr_cmp (
   input  wire        clock_in,
   input  wire        rst_in,
   input  wire        ce_in,
   input  wire        wr_high_in,
   input  wire        wr_mid_in,
   input  wire        wr_low_in,
   input  wire [7:0]  wdata_in,
   input  wire [17:0] bus_addr_in,
   output wire [17:0] value_out,
   output wire        hit_out
);
   reg [1:0] high_q;
   reg [7:0] mid_q;
   reg [7:0] low_q;

   always @(posedge clock_in) begin
      if (rst_in) begin
         high_q <= `BDU_RST_HIGH;
         mid_q  <= `BDU_RST_BYTE;
         low_q  <= `BDU_RST_BYTE;
      end else if (ce_in) begin
         if (wr_high_in) begin
            high_q <= wdata_in[1:0];
         end
         if (wr_mid_in) begin
            mid_q <= wdata_in;
         end
         if (wr_low_in) begin
            low_q <= wdata_in;
         end
      end
   end

   assign value_out = {high_q, mid_q, low_q};
   assign hit_out = (bus_addr_in == value_out);
endmodule // bdu_addr_cmp

`default_nettype wire

// ---- src/bdu_data_cmp.v ----
// bdu_data_cmp.v: first comparator data value and mask store
// assumes: write strobes already qualified by visibility and arm
`timescale 1ns/1ps
`default_nettype none
`include "bdu_consts.vh"

module bdu_data_cmp (
   input  wire        clock_in,
   input  wire        rst_in,
   input  wire        ce_in,
   input  wire        wr_dh_in,
   input  wire        wr_dl_in,
   input  wire        wr_mh_in,
   input  wire        wr_ml_in,
   input  wire [7:0]  wdata_in,
   input  wire [15:0] bus_data_in,
   output wire [15:0] data_out,
   output wire [15:0] mask_out,
   output wire        hit_out
);
   reg [7:0] dh_q;
   reg [7:0] dl_q;
   reg [7:0] mh_q;
   reg [7:0] ml_q;

   always @(posedge clock_in) begin
      if (rst_in) begin
         dh_q <= `BDU_RST_BYTE;
         dl_q <= `BDU_RST_BYTE;
         mh_q <= `BDU_RST_BYTE;
         ml_q <= `BDU_RST_BYTE;
      end else if (ce_in) begin
         if (wr_dh_in) begin
            dh_q <= wdata_in;
         end
         if (wr_dl_in) begin
            dl_q <= wdata_in;
         end
         if (wr_mh_in) begin
            mh_q <= wdata_in;
         end
         if (wr_ml_in) begin
            ml_q <= wdata_in;
         end
      end
   end

   assign data_out = {dh_q, dl_q};
   assign mask_out = {mh_q, ml_q};
   assign hit_out = (((bus_data_in ^ data_out) & mask_out) == 16'h0000);
endmodule // bdu_data_cmp

`default_nettype wire

// ---- verification/bdu_checker.sv ----
// bdu_checker.sv: port assertions for the match register block
// assumes: bound to bdu_match_regs, one clock, sync reset
`timescale 1ns/1ps
`default_nettype none
module bdu_checker (
   input wire logic        clock_in,
   input wire logic        rst_in,
   input wire logic        ce_in,
   input wire logic        psel_in,
   input wire logic        penable_in,
   input wire logic        pwrite_in,
   input wire logic [7:0]  paddr_in,
   input wire logic [31:0] pwdata_in,
   input wire logic [31:0] prdata_out,
   input wire logic        pready_out,
   input wire logic        pslverr_out,
   input wire logic        bus_valid_in,
   input wire logic [2:0]  match_out,
   input wire logic        armed_out
);
   logic [1:0] vis_q;
   default clocking @(posedge clock_in); endclocking
   default disable iff (rst_in);
   // visibility code as last written
   always_ff @(posedge clock_in)
      if (rst_in) vis_q <= 2'h0;
      else if (pready_out && pwrite_in && paddr_in == 8'h80) vis_q <= pwdata_in[1:0];
   sequence setup_s; psel_in && !penable_in; endsequence
   sequence access_s; psel_in && penable_in; endsequence
   ready_time_a:
   assert property (setup_s ##1 access_s |-> !pready_out ##1 pready_out) else $error("ready late");
   ready_once_a:
   assert property (pready_out |=> !pready_out) else $error("ready too long");
   err_ready_a:
   assert property (pslverr_out |-> pready_out) else $error("error without ready");
   upper_zero_a:
   assert property (pready_out && !pwrite_in |-> prdata_out[31:8] == 24'h0) else $error("upper set");
   arm_follow_a:
   assert property (pready_out && pwrite_in && paddr_in == 8'h80 |=> ##1
      armed_out == $past(pwdata_in[7], 2)) else $error("arm not followed");
   data_hidden_a:
   assert property (pready_out && !pwrite_in && paddr_in[7:4] == 4'hB && vis_q != 2'h0
      |-> prdata_out == 32'h0) else $error("data visible");
   none_hidden_a:
   assert property (pready_out && !pwrite_in && paddr_in[7:4] == 4'hA && vis_q == 2'h3
      |-> prdata_out == 32'h0) else $error("address visible");
   match_cause_a:
   assert property (match_out != 3'h0 && $past(ce_in) |-> $past(bus_valid_in))
      else $error("match without cycle");
   freeze_hold_a:
   assert property (!ce_in |=> $stable(match_out) && $stable(armed_out) && $stable(pready_out)
      && $stable(prdata_out)) else $error("state moved while frozen");
endmodule // bdu_checker
`default_nettype wire

// ---- verification/bdu_bus_model.sv ----
// bdu_bus_model.sv: processor bus partner driving monitored cycles
// assumes: commanded by the bench, one cycle per command
`timescale 1ns/1ps
`default_nettype none
module bdu_bus_model (
   input  wire logic        clock_in,
   input  wire logic        rst_in,
   input  wire logic        go_in,
   input  wire logic [17:0] addr_in,
   input  wire logic [15:0] data_in,
   output var  logic        valid_out,
   output var  logic [17:0] addr_out,
   output var  logic [15:0] data_out
);
   // idle cycles out of reset show inverted lines, never held ones; reset cycles load addr_in and data_in
   always_ff @(posedge clock_in) begin
      valid_out <= go_in && !rst_in;
      addr_out <= (go_in || rst_in) ? addr_in : ~addr_out;
      data_out <= (go_in || rst_in) ? data_in : ~data_out;
   end
endmodule // bdu_bus_model
`default_nettype wire

// ---- verification/bdu_match_regs_tb.sv ----
// bdu_match_regs_tb.sv: self-checking bench for the match register block
// assumes: design, bus model and checker compiled before
`timescale 1ns/1ps
`default_nettype none
module bdu_match_regs_tb;
   logic        clock_in, rst_in, psel_in, penable_in, pwrite_in, pready_out, pslverr_out;
   logic        armed_out, go, b_valid, err, tag, ce;
   logic [7:0]  paddr_in;
   logic [31:0] pwdata_in, prdata_out, rd, seed;
   logic [17:0] c_addr, b_addr, adr [3];
   logic [15:0] c_data, b_data, dv, mv;
   logic [2:0]  match_out;
   int          n_mismatch, num_checks;
   bdu_match_regs DUT (.clock_in, .rst_in, .ce_in(ce), .psel_in, .penable_in, .pwrite_in,
      .paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .bus_valid_in(b_valid),
      .bus_addr_in(b_addr), .bus_data_in(b_data), .match_out, .armed_out);
   bdu_bus_model cpu (.clock_in, .rst_in, .go_in(go), .addr_in(c_addr), .data_in(c_data),
      .valid_out(b_valid), .addr_out(b_addr), .data_out(b_data));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic report_and_stop;
      $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   function automatic logic [2:0] exp_m(input logic [17:0] a, input logic [15:0] d);
      for (int i = 0; i < 3; i++) exp_m[i] = (a === adr[i]);
      exp_m[0] = exp_m[0] && (tag || ((d ^ dv) & mv) == 16'h0);
   endfunction
   task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
      int i;
      @(posedge clock_in);
      psel_in <= 1'b1;
      pwrite_in <= w;
      paddr_in <= a;
      pwdata_in <= {24'h0, d};
      @(posedge clock_in);
      penable_in <= 1'b1;
      for (i = 0; i < 20 && pready_out !== 1'b1; i++) @(posedge clock_in);
      if (pready_out !== 1'b1) begin
         n_mismatch++;
         report_and_stop();
      end
      rd = prdata_out;
      err = pslverr_out;
      psel_in <= 1'b0;
      penable_in <= 1'b0;
   endtask
   task automatic bus(input logic [17:0] a, input logic [15:0] d);
      @(posedge clock_in);
      go <= 1'b1;
      c_addr <= a;
      c_data <= d;
      repeat (3) @(posedge clock_in);
      chk(match_out, exp_m(a, d));
      go <= 1'b0;
   endtask
   task automatic set_cmp(input int i, input logic [17:0] a);
      apb(1, 8'h80, i[7:0]);
      apb(1, 8'hA4, {6'h0, a[17:16]});
      apb(1, 8'hA8, a[15:8]);
      apb(1, 8'hAC, a[7:0]);
      adr[i] = a;
   endtask
   initial begin
      clock_in = 0;
      forever #25 clock_in = ~clock_in;
   end
   initial begin
      rst_in = 1;
      {psel_in, penable_in, pwrite_in, go, tag} = 0;
      ce = 1;
      paddr_in = 0;
      pwdata_in = 0;
      c_addr = 0;
      c_data = 0;
      seed = 32'h8C2A8E1B;
      repeat (5) @(posedge clock_in);
      rst_in <= 0;
      apb(0, 8'hAC, 0);
      chk(rd, 0);
      seed = lfsr(seed);
      dv = seed[15:0];
      mv = seed[31:16];
      apb(1, 8'hB0, dv[15:8]);
      apb(1, 8'hB4, dv[7:0]);
      apb(1, 8'hB8, mv[15:8]);
      apb(1, 8'hBC, mv[7:0]);
      for (int i = 0; i < 3; i++) begin
         seed = lfsr(seed);
         set_cmp(i, seed[17:0]);
      end
      // window per visibility code
      for (int v = 0; v < 4; v++) begin
         apb(1, 8'h80, v[7:0]);
         if (v == 1) apb(1, 8'hB8, ~mv[15:8]);
         apb(0, 8'hA4, 0);
         chk(rd, v < 3 ? adr[v % 3][17:16] : 0);
         apb(0, 8'hA8, 0);
         chk(rd, v < 3 ? adr[v % 3][15:8] : 0);
         apb(0, 8'hB8, 0);
         chk(rd, v == 0 ? mv[15:8] : 0);
      end
      apb(0, 8'h80, 0);
      chk(rd, 32'h3);
      // armed unit drops compare writes
      apb(1, 8'h80, 8'h80);
      repeat (2) @(posedge clock_in);
      chk(armed_out, 1);
      apb(1, 8'hA8, ~adr[0][15:8]);
      apb(1, 8'hB4, ~dv[7:0]);
      apb(0, 8'hA8, 0);
      chk(rd, adr[0][15:8]);
      apb(1, 8'h80, 0);
      apb(0, 8'hB4, 0);
      chk(rd, dv[7:0]);
      apb(0, 8'hB8, 0);
      chk(rd, mv[15:8]);
      apb(0, 8'hFC, 0);
      chk(err, 1);
      // exact address hits, one flipped bit misses
      for (int i = 0; i < 3; i++) begin
         bus(adr[i], dv);
         bus(adr[i] ^ (18'h1 << (5 * i)), dv);
      end
      // masked and unmasked data differences
      bus(adr[0], dv ^ ~mv);
      bus(adr[0], dv ^ mv);
      // frozen clock enable holds match state
      bus(adr[1], dv);
      ce <= 1'b0;
      repeat (3) @(posedge clock_in);
      chk(match_out, exp_m(adr[1], dv));
      ce <= 1'b1;
      // tag set ignores data
      apb(1, 8'h84, 8'h20);
      apb(0, 8'h84, 0);
      chk(rd, 32'h20);
      tag = 1;
      bus(adr[0], dv ^ mv);
      apb(1, 8'h84, 0);
      tag = 0;
      for (int n = 0; n < 24; n++) begin
         seed = lfsr(seed);
         bus(seed[0] ? adr[seed[2:1] % 3] : seed[19:2],
            seed[3] ? dv ^ (seed[31:16] & ~mv) : seed[31:16]);
      end
      report_and_stop();
   end
endmodule // bdu_match_regs_tb
bind bdu_match_regs bdu_checker chk_u (.clock_in, .rst_in, .psel_in, .penable_in, .pwrite_in,
   .paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .bus_valid_in,
   .ce_in, .match_out, .armed_out);
`default_nettype wire
